// *** dapw_core.sv ***
// Purpose: Read auto precharge scheduling, bank state and write data capture
// Assumes: Command clock and strobe are much slower than sys_clk and are sampled
// Notes: All pins share one two-stage synchroniser so they stay mutually aligned
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
module dapw_core
    import dapw_pkg::*;
(
    // System
    input wire logic sys_clk,
    input wire logic nrst,
    // Command pins
    input wire logic ck,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic auto_precharge_select,
    input wire logic [BANK_W-1:0] bank_addr,
    // Write data pins
    input wire logic dqs,
    input wire logic [DQ_W-1:0] dq,
    // Mode settings
    input wire logic [LAT_W-1:0] additive_latency,
    input wire logic [LAT_W-1:0] cas_latency,
    input wire logic burst_length_8,
    // Core side
    output logic rd_first,
    output logic [DQ_W-1:0] wr_data,
    output logic wr_valid,
    output logic wr_done,
    output logic [NUM_BANKS-1:0] pre_start,
    output logic [NUM_BANKS-1:0] bank_open,
    output logic [NUM_BANKS-1:0] bank_precharging
);

    dapw_state_s state_r;
    dapw_state_s state_nxt;
    dapw_pins_s pins;
    logic ck_rise;
    logic dqs_rise;
    logic dqs_edge;
    logic cmd_ok;
    logic [2:0] cmd;
    logic [AP_W-1:0] half_bl;
    logic [AP_W-1:0] full_bl;
    logic [AP_W-1:0] ap_len;
    logic [AP_W-1:0] rd_lat;
    logic [AP_W-1:0] wr_lat;
    logic wr_fin;
    logic due;
    logic hit;

    assign pins = {ck, dqs, cs_n, ras_n, cas_n, we_n, auto_precharge_select, bank_addr, dq,
                   additive_latency, cas_latency, burst_length_8};

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_nxt = state_r;
        state_nxt.s1 = pins;
        state_nxt.s2 = state_r.s1;
        state_nxt.ck_d = state_r.s2.ck;
        state_nxt.dqs_d = state_r.s2.dqs;
        state_nxt.pre_start = '0;
        state_nxt.rd_first = 1'b0;
        state_nxt.wr_valid = 1'b0;
        state_nxt.wr_done = 1'b0;
        ck_rise = state_r.s2.ck & ~state_r.ck_d;
        dqs_rise = state_r.s2.dqs & ~state_r.dqs_d;
        dqs_edge = state_r.s2.dqs ^ state_r.dqs_d;
        cmd_ok = ck_rise & ~state_r.s2.cs_n;
        cmd = {state_r.s2.ras_n, state_r.s2.cas_n, state_r.s2.we_n};
        half_bl = state_r.s2.bl8 ? HALF_BL8 : HALF_BL4;
        full_bl = state_r.s2.bl8 ? FULL_BL8 : FULL_BL4;
        ap_len = {1'b0, state_r.s2.add_lat} + half_bl;
        rd_lat = {1'b0, state_r.s2.add_lat} + {1'b0, state_r.s2.cas_lat};
        wr_lat = rd_lat - ONE_CK;
        wr_fin = 1'b0;
        due = 1'b0;
        hit = 1'b0;

        // Read data launch point
        if (ck_rise) begin
            state_nxt.rd_pipe = {state_r.rd_pipe[RD_PIPE_W-2:0], 1'b0};
            if (rd_lat != '0) begin
                state_nxt.rd_first = state_r.rd_pipe[rd_lat - ONE_CK];
            end
            if (cmd_ok && cmd == CMD_READ && state_r.bank[state_r.s2.bank].active) begin
                state_nxt.rd_pipe[0] = 1'b1;
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // Write burst: wait out latency, then take data on strobe edges
        case (state_r.wr_st)
            WR_IDLE: begin
                if (cmd_ok && cmd == CMD_WRITE && state_r.bank[state_r.s2.bank].active) begin
                    state_nxt.wr_st = WR_WAIT;
                    state_nxt.wr_bank = state_r.s2.bank;
                    state_nxt.wr_ap = state_r.s2.ap;
                    // Arm one clock early to absorb the strobe offset tolerance
                    state_nxt.wr_cnt = wr_lat - ONE_CK;
                end
            end
            WR_WAIT: begin
                if (state_r.wr_cnt == '0) begin
                    state_nxt.wr_st = WR_PRE;
                end else if (ck_rise) begin
                    state_nxt.wr_cnt = state_r.wr_cnt - ONE_CK;
                end
            end
            WR_PRE: begin
                if (dqs_rise) begin
                    state_nxt.wr_data = state_r.s2.dq;
                    state_nxt.wr_valid = 1'b1;
                    state_nxt.wr_cnt = full_bl - ONE_CK;
                    state_nxt.wr_st = WR_BURST;
                end
            end
            WR_BURST: begin
                if (dqs_edge) begin
                    state_nxt.wr_data = state_r.s2.dq;
                    state_nxt.wr_valid = 1'b1;
                    state_nxt.wr_cnt = state_r.wr_cnt - ONE_CK;
                    if (state_r.wr_cnt == ONE_CK) begin
                        state_nxt.wr_st = WR_IDLE;
                        state_nxt.wr_done = 1'b1;
                        wr_fin = 1'b1;
                    end
                end
            end
            default: begin
                state_nxt.wr_st = WR_IDLE;
            end
        endcase

        ////////////////////////////////////////////////////////////////////////
        // Each bank keeps its own timers, so one bank closing never stalls others
        for (int b = 0; b < NUM_BANKS; b++) begin
            if (state_r.bank[b].ras_cnt != '0) begin
                state_nxt.bank[b].ras_cnt = state_r.bank[b].ras_cnt - 8'h01;
            end
            if (state_r.bank[b].rtp_cnt != '0) begin
                state_nxt.bank[b].rtp_cnt = state_r.bank[b].rtp_cnt - 8'h01;
            end
            if (state_r.bank[b].rp_cnt != '0) begin
                state_nxt.bank[b].rp_cnt = state_r.bank[b].rp_cnt - 8'h01;
            end

            if (ck_rise && state_r.bank[b].ap_pend) begin
                state_nxt.bank[b].ap_cnt = state_r.bank[b].ap_cnt - ONE_CK;
                // Last four-bit prefetch happens two clocks before the scheduled edge
                if (state_r.bank[b].ap_cnt == PREFETCH_GAP + ONE_CK) begin
                    state_nxt.bank[b].rtp_cnt = RTP_CYC;
                end
            end

            due = state_r.bank[b].wait_pre
                | (ck_rise & state_r.bank[b].ap_pend & (state_r.bank[b].ap_cnt == ONE_CK));
            if (due) begin
                state_nxt.bank[b].ap_pend = 1'b0;
                // Postponed starts fire on sys_clk, not on the next command clock edge
                if (state_r.bank[b].ras_cnt == '0 && state_r.bank[b].rtp_cnt == '0) begin
                    state_nxt.bank[b].wait_pre = 1'b0;
                    state_nxt.bank[b].active = 1'b0;
                    state_nxt.bank[b].rp_cnt = RP_CYC;
                    state_nxt.pre_start[b] = 1'b1;
                end else begin
                    state_nxt.bank[b].wait_pre = 1'b1;
                end
            end

            if (wr_fin && state_r.wr_ap && state_r.wr_bank == BANK_W'(b)) begin
                state_nxt.bank[b].wait_pre = 1'b1;
            end

            hit = cmd_ok && state_r.s2.bank == BANK_W'(b);
            if (hit && cmd == CMD_ACT && !state_r.bank[b].active && state_r.bank[b].rp_cnt == '0) begin
                state_nxt.bank[b].active = 1'b1;
                state_nxt.bank[b].ras_cnt = RAS_CYC;
            end
            if (hit && cmd == CMD_READ && state_r.s2.ap && state_r.bank[b].active
                && !state_r.bank[b].ap_pend && !state_r.bank[b].wait_pre) begin
                state_nxt.bank[b].ap_pend = 1'b1;
                state_nxt.bank[b].ap_cnt = ap_len;
                if (ap_len == PREFETCH_GAP) begin
                    state_nxt.bank[b].rtp_cnt = RTP_CYC;
                end
            end
            // Explicit precharge; the select bit widens it to every bank
            if (cmd_ok && cmd == CMD_PRE && state_r.bank[b].active
                && (state_r.s2.ap || state_r.s2.bank == BANK_W'(b))) begin
                state_nxt.bank[b].active = 1'b0;
                state_nxt.bank[b].ap_pend = 1'b0;
                state_nxt.bank[b].wait_pre = 1'b0;
                state_nxt.bank[b].rp_cnt = RP_CYC;
                state_nxt.pre_start[b] = 1'b1;
            end
            state_nxt.prech[b] = (state_nxt.bank[b].rp_cnt != '0);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign rd_first = state_r.rd_first;
    assign wr_data = state_r.wr_data;
    assign wr_valid = state_r.wr_valid;
    assign wr_done = state_r.wr_done;
    assign pre_start = state_r.pre_start;

    for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank_out
        assign bank_open[g] = state_r.bank[g].active;
        assign bank_precharging[g] = state_r.prech[g];
    end

endmodule

// *** dapw_core_sva.sv ***
// Purpose: Port level checks of precharge, read and write capture pulses
// Assumes: One sys_clk domain, nrst asynchronous active low
// Notes: Bound to every dapw_core instance
`timescale 1ns/10ps
module dapw_core_chk
    import dapw_pkg::*;
(
    // System
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ck,
    // Observed outputs
    input wire logic rd_first,
    input wire logic wr_valid,
    input wire logic wr_done,
    input wire logic [NUM_BANKS-1:0] pre_start,
    input wire logic [NUM_BANKS-1:0] bank_open,
    input wire logic [NUM_BANKS-1:0] bank_precharging
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////
    sequence s_pre;
        |pre_start;
    endsequence
    // Read data come while the command clock is high in this and the previous sample
    sequence s_ck_seen;
        $past(ck) && ck;
    endsequence
    property p_pre_close;
        s_pre |-> (bank_open & pre_start) == '0;
    endproperty
    property p_close_cause;
        |($past(bank_open) & ~bank_open) |-> ($past(bank_open) & ~bank_open & ~pre_start) == '0;
    endproperty
    property p_pre_pulse;
        s_pre |=> (pre_start & $past(pre_start)) == '0;
    endproperty
    property p_prech_start;
        |(bank_precharging & ~$past(bank_precharging)) |-> (bank_precharging & ~$past(bank_precharging) & ~pre_start) == '0;
    endproperty
    property p_excl;
        (bank_open & bank_precharging) == '0;
    endproperty
    property p_rd_ck;
        rd_first |-> s_ck_seen;
    endproperty
    property p_rd_pulse;
        rd_first |=> !rd_first;
    endproperty
    property p_wr_pulse;
        wr_valid |=> !wr_valid;
    endproperty
    property p_wr_done;
        wr_done |-> wr_valid;
    endproperty
    a_pre_close: assert property (p_pre_close) else $error("bank open at precharge");
    a_close_cause: assert property (p_close_cause) else $error("row closed without precharge");
    a_pre_pulse: assert property (p_pre_pulse) else $error("precharge pulse too long");
    a_prech_start: assert property (p_prech_start) else $error("precharge period start");
    a_excl: assert property (p_excl) else $error("open while precharging");
    a_rd_ck: assert property (p_rd_ck) else $error("read data off clock");
    a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse too long");
    a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too long");
    a_wr_done: assert property (p_wr_done) else $error("done without element");
endmodule
bind dapw_core dapw_core_chk u_chk (.sys_clk(sys_clk), .nrst(nrst), .ck(ck), .rd_first(rd_first),
    .wr_valid(wr_valid), .wr_done(wr_done), .pre_start(pre_start), .bank_open(bank_open),
    .bank_precharging(bank_precharging));

// *** dapw_ctl_model.sv ***
// Purpose: Memory controller model driving commands, strobe and data
// Assumes: Command clock free running at eight sys_clk per period
// Notes: Released bank, select and data pins show inverted values, never the last one
`timescale 1ns/10ps
module dapw_ctl_model
    import dapw_pkg::*;
(
    // System
    input wire logic sys_clk,
    // Mode settings
    input wire logic [LAT_W-1:0] add_lat,
    input wire logic bl8,
    // Pins to device
    output logic ck,
    output logic [2:0] cmd,
    output logic cs_n,
    output logic ap,
    output logic [BANK_W-1:0] bank,
    output logic dqs,
    output logic [DQ_W-1:0] dq
);
    // Bank ready time assumes precharge no sooner than two clocks past prefetch
    localparam int CK_NS = 8 * SYS_PERIOD_NS;
    localparam int RAP_CK = ((RTP_NS > 2 * CK_NS ? RTP_NS : 2 * CK_NS) + RP_NS + CK_NS - 1) / CK_NS;
    logic [1:0] ph;
    int nck;
    int act_ok [NUM_BANKS];
    initial begin
        ck = 1'b0;
        ph = 2'h0;
        cmd = 3'h7;
        cs_n = 1'b1;
        ap = 1'b0;
        bank = 3'h0;
        dqs = 1'b0;
        dq = 8'h00;
    end
    always @(posedge sys_clk) begin
        ph <= ph + 2'h1;
        if (ph == 2'h3) begin
            ck <= ~ck;
            if (!ck) begin
                nck <= nck + 1;
            end
        end
    end
    ////////////////////////////////////////////////////////////
    // Pins change on the falling clock so they are settled at the rise
    task automatic step_fall();
        do @(posedge sys_clk); while (!(ph == 2'h3 && ck));
    endtask
    // One command every two clocks keeps the other bank spacing
    task automatic issue(input logic [2:0] c, input logic [BANK_W-1:0] b, input logic a);
        step_fall();
        // Activate waits for the bank's own timer
        while (c == CMD_ACT && nck + 1 < act_ok[b]) step_fall();
        if (c == CMD_READ && a) begin
            act_ok[b] = nck + 1 + int'(add_lat) + (bl8 ? 2 : 0) + RAP_CK;
        end
        cmd <= c;
        cs_n <= 1'b0;
        bank <= b;
        ap <= a;
        step_fall();
        cs_n <= 1'b1;
        cmd <= 3'h7;
        bank <= ~b;
        ap <= ~a;
    endtask
    // Strobe low as preamble, first rise at write latency
    task automatic burst(input int wl, input int n, input logic [DQ_W-1:0] d0);
        for (int i = 1; i < wl; i++) step_fall();
        dq <= d0;
        for (int i = 0; i < 4 * n; i++) begin
            @(posedge sys_clk);
            if (i % 4 == 3) begin
                dqs <= ~dqs;
            end
            if (i % 4 == 1) begin
                dq <= d0 + DQ_W'(i / 4);
            end
        end
        // Hold past the last strobe edge so the device samples the final element
        repeat (2) @(posedge sys_clk);
        dq <= ~dq;
    endtask
endmodule

// *** dapw_pkg.sv ***
// Purpose: Constants and carrier types for the DRAM read auto precharge and write start logic
// Assumes: sys_clk at 10 MHz samples the command clock, strobe and all pins
// Notes: Times are whole nanoseconds; cycle counts derive from them rounding up
// Notes on behaviour
// - Auto precharge select on read engages auto precharge
// - Precharge at additive latency plus half burst
// - Postpone precharge until both minima met
// - Precharge period counts from actual precharge start
// - Precharge never before two clocks past prefetch
// - Auto precharge runs concurrently with other banks
// - Write latency equals read latency minus one
// - Write with auto precharge closes row after burst
// - Write data captured on successive strobe edges
// - Read latency is additive plus cas latency
package dapw_pkg;

    localparam int SYS_PERIOD_NS = 100;
    localparam int RTP_NS = 8;
    localparam int RP_NS = 15;
    localparam int RAS_NS = 40;

    localparam int CNT_W = 8;
    localparam int RTP_RAW = (RTP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int RP_RAW = (RP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int RAS_RAW = (RAS_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam logic [CNT_W-1:0] RTP_CYC = CNT_W'((RTP_RAW < 1) ? 1 : RTP_RAW);
    localparam logic [CNT_W-1:0] RP_CYC = CNT_W'((RP_RAW < 1) ? 1 : RP_RAW);
    localparam logic [CNT_W-1:0] RAS_CYC = CNT_W'((RAS_RAW < 1) ? 1 : RAS_RAW);

    localparam int NUM_BANKS = 8;
    localparam int BANK_W = 3;
    localparam int DQ_W = 8;
    localparam int LAT_W = 3;
    localparam int AP_W = 4;
    localparam int RD_PIPE_W = 16;

    // Command code is {ras_n, cas_n, we_n} with chip select low
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_READ = 3'h5;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    localparam logic [2:0] CMD_PRE = 3'h2;

    localparam logic [AP_W-1:0] HALF_BL4 = 4'h2;
    localparam logic [AP_W-1:0] HALF_BL8 = 4'h4;
    localparam logic [AP_W-1:0] FULL_BL4 = 4'h4;
    localparam logic [AP_W-1:0] FULL_BL8 = 4'h8;
    localparam logic [AP_W-1:0] PREFETCH_GAP = 4'h2;
    localparam logic [AP_W-1:0] ONE_CK = 4'h1;

    typedef enum logic [1:0] {WR_IDLE, WR_WAIT, WR_PRE, WR_BURST} dapw_wr_e;

    typedef struct packed {
        logic ck;
        logic dqs;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic ap;
        logic [BANK_W-1:0] bank;
        logic [DQ_W-1:0] dq;
        logic [LAT_W-1:0] add_lat;
        logic [LAT_W-1:0] cas_lat;
        logic bl8;
    } dapw_pins_s;

    typedef struct packed {
        logic active;
        logic [CNT_W-1:0] ras_cnt;
        logic ap_pend;
        logic [AP_W-1:0] ap_cnt;
        logic [CNT_W-1:0] rtp_cnt;
        logic wait_pre;
        logic [CNT_W-1:0] rp_cnt;
    } dapw_bank_s;

    typedef struct packed {
        dapw_pins_s s1;
        dapw_pins_s s2;
        logic ck_d;
        logic dqs_d;
        dapw_bank_s [NUM_BANKS-1:0] bank;
        logic [RD_PIPE_W-1:0] rd_pipe;
        logic rd_first;
        dapw_wr_e wr_st;
        logic [AP_W-1:0] wr_cnt;
        logic [BANK_W-1:0] wr_bank;
        logic wr_ap;
        logic [DQ_W-1:0] wr_data;
        logic wr_valid;
        logic wr_done;
        logic [NUM_BANKS-1:0] pre_start;
        logic [NUM_BANKS-1:0] prech;
    } dapw_state_s;

endpackage

// *** testbench.sv ***
// Purpose: Self checking bench for dapw_core
// Assumes: additive plus cas latency at least three so write latency is two or more
// Notes: Latencies judged by the gap between precharge and read pulses
`timescale 1ns/10ps
module testbench
    import dapw_pkg::*;
;
    logic sys_clk, nrst, ck, cs_n, ap, dqs, bl8, rd_first, wr_valid, wr_done;
    logic [2:0] cmd;
    logic [LAT_W-1:0] add_lat, cas_lat;
    logic [BANK_W-1:0] bank;
    logic [DQ_W-1:0] dq, wr_data;
    logic [NUM_BANKS-1:0] pre_start, bank_open, bank_precharging;
    int num_errors, n_compared, cyc, t_pre, t_rd;
    dapw_ctl_model ctl (.sys_clk(sys_clk), .add_lat(add_lat), .bl8(bl8), .ck(ck), .cmd(cmd), .cs_n(cs_n), .ap(ap),
        .bank(bank), .dqs(dqs), .dq(dq));
    dapw_core dut (.sys_clk(sys_clk), .nrst(nrst), .ck(ck), .cs_n(cs_n), .ras_n(cmd[2]), .cas_n(cmd[1]),
        .we_n(cmd[0]), .auto_precharge_select(ap), .bank_addr(bank), .dqs(dqs), .dq(dq), .additive_latency(add_lat),
        .cas_latency(cas_lat), .burst_length_8(bl8), .rd_first(rd_first), .wr_data(wr_data), .wr_valid(wr_valid),
        .wr_done(wr_done), .pre_start(pre_start), .bank_open(bank_open), .bank_precharging(bank_precharging));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // Ceiling well above the few hundred cycles the scenarios need
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (|pre_start === 1'b1) t_pre = cyc;
        if (rd_first === 1'b1) t_rd = cyc;
        if (cyc == 20000) begin
            num_errors++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic sc_read_ap(input logic [LAT_W-1:0] a, input logic [LAT_W-1:0] c, input logic b8);
        int half;
        half = b8 ? 4 : 2;
        add_lat <= a;
        cas_lat <= c;
        bl8 <= b8;
        ctl.issue(CMD_ACT, 3'h1, 1'b0);
        ctl.issue(CMD_ACT, 3'h3, 1'b0);
        repeat (4) @(posedge sys_clk);
        check(bank_open, 8'h0a);
        t_pre = -1;
        t_rd = -1;
        ctl.issue(CMD_READ, 3'h1, 1'b1);
        for (int k = 0; k < 200 && (t_pre < 0 || t_rd < 0); k++) @(posedge sys_clk);
        check(t_rd - t_pre, (int'(c) - half) * 8);
        check(bank_open, 8'h08);
        ctl.issue(CMD_READ, 3'h3, 1'b1);
        ctl.issue(CMD_ACT, 3'h3, 1'b0);
        check(bank_open, 8'h08);
        ctl.issue(CMD_PRE, b8 ? 3'h0 : 3'h3, b8);
        repeat (8) @(posedge sys_clk);
        check(bank_open | bank_precharging, 8'h00);
    endtask
    task automatic sc_write_ap(input logic [LAT_W-1:0] a, input logic [LAT_W-1:0] c, input logic b8);
        int got;
        int n;
        got = 0;
        n = b8 ? 8 : 4;
        add_lat <= a;
        cas_lat <= c;
        bl8 <= b8;
        ctl.issue(CMD_ACT, 3'h6, 1'b0);
        ctl.issue(CMD_WRITE, 3'h6, 1'b1);
        fork
            ctl.burst(int'(a) + int'(c) - 1, n, 8'h5a);
            for (int k = 0; k < 300 && got < n; k++) begin
                @(posedge sys_clk);
                if (wr_valid === 1'b1) begin
                    check(wr_data, 8'h5a + got);
                    got++;
                    check(wr_done, got == n);
                end
            end
        join
        check(got, n);
        for (int k = 0; k < 20 && bank_open[6] !== 1'b0; k++) @(posedge sys_clk);
        check(bank_open, 8'h00);
    endtask
    initial begin
        nrst = 1'b0;
        add_lat = 3'h0;
        cas_lat = 3'h3;
        bl8 = 1'b0;
        num_errors = 0;
        n_compared = 0;
        cyc = 0;
        t_pre = -1;
        t_rd = -1;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (16) @(posedge sys_clk);
        sc_read_ap(3'h0, 3'h3, 1'b0);
        sc_read_ap(3'h1, 3'h4, 1'b1);
        sc_write_ap(3'h0, 3'h3, 1'b0);
        sc_write_ap(3'h1, 3'h3, 1'b1);
        conclude();
    end
endmodule
